/* File: rtl/nss_pkg.sv */
/*
 package for the nibble exchange and subtract datapath slice.
 assumes nothing beyond a systemverilog tool.
*/
package nss_pkg;
   localparam int DATA_W = 8;
   localparam int ADDR_W = 7;
   localparam int NIB_HI = 7;
   localparam int NIB_MID_HI = 4;
   localparam int NIB_MID_LO = 3;
   localparam logic [7:0] W_RESET = 8'h00;
   localparam logic C_RESET = 1'b0;
   localparam logic DEST_W = 1'b0;
   localparam logic DEST_F = 1'b1;
   localparam int SYNC_STAGES = 2;
   // one program word, one instruction cycle
   localparam int OP_CYCLES = 1;

   typedef enum logic [1:0] {
      NSS_OP_NONE = 2'h0,
      NSS_OP_NIBBLE_EXCHANGE = 2'h1,
      NSS_OP_REGISTER_SUBTRACT = 2'h3,
      NSS_OP_LITERAL_SUBTRACT = 2'h2
   } nss_op_t;
endpackage : nss_pkg

/* File: rtl/nss_subtractor.sv */
/*
 eight bit two's complement subtractor with borrow-style carry out.
 assumes the caller registers the outputs.
*/
`timescale 1ns/1ps
`default_nettype none
module nss_subtractor
   import nss_pkg::*;
#(
   parameter int WIDTH = DATA_W
) (
   // operands
   input wire logic [WIDTH-1:0] i_minuend,
   input wire logic [WIDTH-1:0] i_subtrahend,
   // result
   output logic [WIDTH-1:0] o_diff,
   output logic o_carry
);
   logic [WIDTH:0] sum;

   // minuend + ~subtrahend + 1; top bit set means no borrow
   always_comb begin
      sum = {1'b0, i_minuend} + {1'b0, ~i_subtrahend} + {{WIDTH{1'b0}}, 1'b1};
      o_diff = sum[WIDTH-1:0];
      o_carry = sum[WIDTH];
   end
endmodule : nss_subtractor
`default_nettype wire

/* File: rtl/nss_datapath.sv */
/*
 execute slice: nibble exchange and the two subtract operations.
 assumes the core presents a decoded op with its file register value
 for one clock, and writes back the file register from o_f_we.
*/
// Function
// - nibble exchange puts source bits 3:0 in result 7:4 and 7:4 in 3:0.
// - nibble exchange result goes to w when dest is 0, to the file when 1.
// - a positive nonzero difference leaves carry set to 1.
// - a zero difference stores zero and sets carry to 1.
// - a borrow clears carry to 0 and the result wraps modulo 256.
// - register subtract forms file minus w and routes by dest.
// - literal subtract forms literal minus w and always writes w.
`timescale 1ns/1ps
`default_nettype none
module nss_datapath
   import nss_pkg::*;
#(
   parameter int WIDTH = DATA_W,
   parameter int AW = ADDR_W
) (
   // clock and reset
   input wire logic i_clock,
   input wire logic i_rst_b,
   // decoded instruction
   input wire nss_op_t i_op,
   input wire logic [AW-1:0] i_f_addr,
   input wire logic i_dest,
   input wire logic [WIDTH-1:0] i_literal,
   input wire logic [WIDTH-1:0] i_f_data,
   // results
   output logic [WIDTH-1:0] o_w,
   output logic o_carry,
   output logic o_f_we,
   output logic [AW-1:0] o_f_addr,
   output logic [WIDTH-1:0] o_f_wdata,
   output logic o_done
);
   logic [SYNC_STAGES-1:0] rst_sync;
   logic rst_n;
   logic [WIDTH-1:0] w;
   logic carry;
   logic f_we;
   logic [AW-1:0] f_addr;
   logic [WIDTH-1:0] f_wdata;
   logic done;
   logic [WIDTH-1:0] next_w;
   logic next_carry;
   logic next_f_we;
   logic [AW-1:0] next_f_addr;
   logic [WIDTH-1:0] next_f_wdata;
   logic next_done;
   logic [WIDTH-1:0] sub_a;
   logic [WIDTH-1:0] diff;
   logic sub_carry;
   logic [WIDTH-1:0] swapped;
   logic [WIDTH-1:0] result;
   logic to_file;

   always_ff @(posedge i_clock or negedge i_rst_b) begin
      if (!i_rst_b) begin
         rst_sync <= '0;
      end else begin
         rst_sync <= {rst_sync[SYNC_STAGES-2:0], 1'b1};
      end
   end
   assign rst_n = rst_sync[SYNC_STAGES-1];

   // literal subtract uses k as minuend, register subtract the file value
   assign sub_a = (i_op == NSS_OP_LITERAL_SUBTRACT) ? i_literal : i_f_data;

   nss_subtractor #(
      .WIDTH(WIDTH)
   ) nss_subtractor_i (
      .i_minuend(sub_a),
      .i_subtrahend(w),
      .o_diff(diff),
      .o_carry(sub_carry)
   );

   assign swapped = {i_f_data[NIB_MID_LO:0], i_f_data[NIB_HI:NIB_MID_HI]};

   always_comb begin
      next_w = w;
      next_carry = carry;
      next_f_we = 1'b0;
      next_f_addr = f_addr;
      next_f_wdata = f_wdata;
      next_done = 1'b0;
      result = swapped;
      to_file = 1'b0;
      unique case (i_op)
         NSS_OP_NONE: begin
            result = swapped;
         end
         NSS_OP_NIBBLE_EXCHANGE: begin
            result = swapped;
            to_file = (i_dest == DEST_F);
            next_done = 1'b1;
         end
         NSS_OP_REGISTER_SUBTRACT: begin
            result = diff;
            to_file = (i_dest == DEST_F);
            next_carry = sub_carry;
            next_done = 1'b1;
         end
         NSS_OP_LITERAL_SUBTRACT: begin
            result = diff;
            to_file = 1'b0;
            next_carry = sub_carry;
            next_done = 1'b1;
         end
      endcase
      if (next_done) begin
         if (to_file) begin
            next_f_we = 1'b1;
            next_f_addr = i_f_addr;
            next_f_wdata = result;
         end else begin
            next_w = result;
         end
      end
   end

   always_ff @(posedge i_clock or negedge rst_n) begin
      if (!rst_n) begin
         w <= W_RESET;
         carry <= C_RESET;
         f_we <= 1'b0;
         f_addr <= '0;
         f_wdata <= '0;
         done <= 1'b0;
      end else begin
         w <= next_w;
         carry <= next_carry;
         f_we <= next_f_we;
         f_addr <= next_f_addr;
         f_wdata <= next_f_wdata;
         done <= next_done;
      end
   end

   assign o_w = w;
   assign o_carry = carry;
   assign o_f_we = f_we;
   assign o_f_addr = f_addr;
   assign o_f_wdata = f_wdata;
   assign o_done = done;

   default clocking cb @(posedge i_clock);
   endclocking
   default disable iff (!rst_n);

   swap_to_w_a: assert property (
      (i_op == NSS_OP_NIBBLE_EXCHANGE && i_dest == DEST_W) |=>
      (o_w == {$past(i_f_data[3:0]), $past(i_f_data[7:4])}))
      else $error("nibble exchange to w wrong");

   swap_to_file_a: assert property (
      (i_op == NSS_OP_NIBBLE_EXCHANGE && i_dest == DEST_F) |=>
      (o_f_we && o_f_addr == $past(i_f_addr) && $stable(o_w)
       && o_f_wdata == {$past(i_f_data[3:0]), $past(i_f_data[7:4])}))
      else $error("nibble exchange to file wrong");

   swap_flags_a: assert property (
      (i_op == NSS_OP_NIBBLE_EXCHANGE) |=> ($stable(o_carry) && o_done))
      else $error("nibble exchange touched carry");

   sub_positive_a: assert property (
      (i_op == NSS_OP_LITERAL_SUBTRACT && i_literal > o_w) |=> o_carry)
      else $error("positive difference lost carry");

   sub_zero_a: assert property (
      (i_op == NSS_OP_LITERAL_SUBTRACT && i_literal == o_w) |=>
      (o_carry && o_w == 8'h00))
      else $error("zero difference wrong");

   sub_borrow_a: assert property (
      (i_op == NSS_OP_REGISTER_SUBTRACT && i_dest == DEST_F
       && i_f_data < o_w) |=>
      (!o_carry && o_f_wdata == $past(i_f_data) - $past(o_w)))
      else $error("borrow not signalled");

   reg_sub_route_a: assert property (
      (i_op == NSS_OP_REGISTER_SUBTRACT && i_dest == DEST_W) |=>
      (!o_f_we && o_w == $past(i_f_data) - $past(o_w)))
      else $error("register subtract to w wrong");

   lit_sub_w_a: assert property (
      (i_op == NSS_OP_LITERAL_SUBTRACT) |=>
      (!o_f_we && o_w == $past(i_literal) - $past(o_w)))
      else $error("literal subtract wrong");

   idle_quiet_a: assert property (
      (i_op == NSS_OP_NONE) |=> (!o_f_we && !o_done && $stable(o_w)))
      else $error("idle cycle changed state");

   op_done_a: assert property (
      (i_op != NSS_OP_NONE) |=> o_done)
      else $error("op did not complete in one cycle");

   reg_sub_carry_a: assert property (
      (i_op == NSS_OP_REGISTER_SUBTRACT) |=>
      (o_carry == ($past(i_f_data) >= $past(o_w))))
      else $error("register subtract carry wrong");

   reg_sub_zero_a: assert property (
      (i_op == NSS_OP_REGISTER_SUBTRACT && i_dest == DEST_F
       && i_f_data == o_w) |=>
      (o_carry && o_f_we && o_f_wdata == 8'h00))
      else $error("register subtract zero wrong");

   lit_borrow_a: assert property (
      (i_op == NSS_OP_LITERAL_SUBTRACT && i_literal < o_w) |=>
      (!o_carry && o_w == $past(i_literal) - $past(o_w)))
      else $error("literal subtract borrow wrong");

   cov_swap_file: cover property (
      i_op == NSS_OP_NIBBLE_EXCHANGE && i_dest == DEST_F);
   cov_borrow: cover property (
      i_op == NSS_OP_REGISTER_SUBTRACT ##1 !o_carry);
   cov_zero: cover property (
      i_op == NSS_OP_LITERAL_SUBTRACT ##1 (o_carry && o_w == 8'h00));
   cov_positive: cover property (
      i_op == NSS_OP_LITERAL_SUBTRACT && i_literal > o_w);
endmodule : nss_datapath
`default_nettype wire

/* File: testbench/nibble_swap_and_subtract_carry_tb.sv */
/*
 self-checking bench for the nibble exchange and subtract slice.
 assumes nss_pkg and nss_datapath are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, x, g) begin n_checks++; if ((g) !== (x)) begin \
   $display("[FAIL] %s expected %h seen %h", n, x, g); error_cnt++; end end
module nibble_swap_and_subtract_carry_tb;
   import nss_pkg::*;
   typedef struct packed {
      logic [7:0] w;
      logic c;
      logic we;
      logic [6:0] a;
      logic [7:0] d;
   } nss_exp_t;
   logic i_clock = 1'b0;
   logic i_rst_b = 1'b0;
   nss_op_t i_op = NSS_OP_NONE;
   logic [6:0] i_f_addr = 7'h00;
   logic i_dest = 1'b0;
   logic [7:0] i_literal = 8'h00;
   logic [7:0] i_f_data = 8'h00;
   logic [7:0] o_w, o_f_wdata;
   logic o_carry, o_f_we, o_done;
   logic [6:0] o_f_addr;
   nss_exp_t q[$];
   nss_exp_t got_e;
   logic [7:0] mw = 8'h00;
   logic mc = 1'b0;
   int error_cnt = 0;
   int n_checks = 0;
   integer seed = 32'hddc9189f;
   logic [31:0] r;

   always #25 i_clock = ~i_clock;

   nss_datapath nss_datapath_i (.i_clock(i_clock), .i_rst_b(i_rst_b),
      .i_op(i_op), .i_f_addr(i_f_addr), .i_dest(i_dest),
      .i_literal(i_literal), .i_f_data(i_f_data), .o_w(o_w),
      .o_carry(o_carry), .o_f_we(o_f_we), .o_f_addr(o_f_addr),
      .o_f_wdata(o_f_wdata), .o_done(o_done));

   // model the op, note the expected result, then present it
   task automatic issue(input nss_op_t op, input logic [7:0] f,
         input logic [7:0] k, input logic d, input logic [6:0] a);
      nss_exp_t e;
      logic [8:0] s;
      s = ((op == NSS_OP_LITERAL_SUBTRACT) ? {1'b0, k} : {1'b0, f})
         - {1'b0, mw};
      e = '{w: mw, c: mc, we: 1'b0, a: a, d: 8'h00};
      if (op == NSS_OP_NIBBLE_EXCHANGE) begin
         e.d = {f[3:0], f[7:4]};
      end else begin
         e.d = s[7:0];
         e.c = ~s[8];
      end
      if (op == NSS_OP_LITERAL_SUBTRACT || d == DEST_W) begin
         e.w = e.d;
      end else begin
         e.we = 1'b1;
      end
      @(posedge i_clock);
      i_op <= op;
      i_f_data <= f;
      i_literal <= k;
      i_dest <= d;
      i_f_addr <= a;
      if (op != NSS_OP_NONE) begin
         mw = e.w;
         mc = e.c;
         q.push_back(e);
      end
   endtask : issue

   task automatic report_and_stop();
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : report_and_stop

   // each done pulse retires the oldest note
   always @(negedge i_clock) begin
      if (o_done === 1'b1) begin
         `CHK("done with no op", 1'b1, q.size() != 0)
         if (q.size() != 0) begin
            got_e = q.pop_front();
            `CHK("w", got_e.w, o_w)
            `CHK("carry", got_e.c, o_carry)
            `CHK("file write", got_e.we, o_f_we)
            if (got_e.we) begin
               `CHK("file addr", got_e.a, o_f_addr)
               `CHK("file data", got_e.d, o_f_wdata)
            end
         end
      end else begin
         `CHK("write without done", 1'b0, o_f_we)
      end
   end

   initial begin
      repeat (5) @(posedge i_clock);
      i_rst_b <= 1'b1;
      repeat (3) @(posedge i_clock);
      // w is loaded by exchange, then 2 minus w of 1, 2 and 3
      issue(NSS_OP_NIBBLE_EXCHANGE, 8'ha5, 8'h00, DEST_W, 7'h11);
      issue(NSS_OP_NIBBLE_EXCHANGE, 8'h10, 8'h00, DEST_W, 7'h12);
      issue(NSS_OP_LITERAL_SUBTRACT, 8'h00, 8'h02, DEST_F, 7'h13);
      issue(NSS_OP_NIBBLE_EXCHANGE, 8'h20, 8'h00, DEST_W, 7'h14);
      issue(NSS_OP_LITERAL_SUBTRACT, 8'h00, 8'h02, DEST_F, 7'h15);
      issue(NSS_OP_NIBBLE_EXCHANGE, 8'h30, 8'h00, DEST_W, 7'h16);
      issue(NSS_OP_LITERAL_SUBTRACT, 8'h00, 8'h02, DEST_F, 7'h17);
      issue(NSS_OP_NIBBLE_EXCHANGE, 8'h20, 8'h00, DEST_W, 7'h18);
      issue(NSS_OP_REGISTER_SUBTRACT, 8'h03, 8'h00, DEST_F, 7'h19);
      issue(NSS_OP_REGISTER_SUBTRACT, 8'h02, 8'h00, DEST_F, 7'h1a);
      issue(NSS_OP_REGISTER_SUBTRACT, 8'h01, 8'h00, DEST_F, 7'h1b);
      issue(NSS_OP_REGISTER_SUBTRACT, 8'h05, 8'h00, DEST_W, 7'h1c);
      issue(NSS_OP_NIBBLE_EXCHANGE, 8'h3c, 8'h00, DEST_F, 7'h7f);
      issue(NSS_OP_NONE, 8'h00, 8'h00, DEST_W, 7'h00);
      for (int i = 0; i < 400; i++) begin
         r = $random(seed);
         issue(nss_op_t'(r[1:0]), r[9:2], r[17:10], r[18], r[25:19]);
      end
      issue(NSS_OP_NONE, 8'h00, 8'h00, DEST_W, 7'h00);
      for (int t = 0; t < 20 && q.size() != 0; t++) @(posedge i_clock);
      `CHK("pending results", 0, q.size())
      @(posedge i_clock);
      i_rst_b <= 1'b0;
      @(negedge i_clock);
      `CHK("w in reset", 8'h00, o_w)
      `CHK("carry in reset", 1'b0, o_carry)
      `CHK("done in reset", 1'b0, o_done)
      report_and_stop();
   end
endmodule : nibble_swap_and_subtract_carry_tb
`default_nettype wire
